//--- verilog/dtsw_pkg.sv
`default_nettype none
package dtsw_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] ADR_CLK_SEL = 8'h00;
	localparam logic [7:0] ADR_MODE = 8'h04;
	localparam logic [7:0] ADR_OUT_CTRL = 8'h08;
	localparam logic [7:0] ADR_LOW_CMP = 8'h0C;
	localparam logic [7:0] ADR_HIGH_CMP = 8'h10;
	localparam logic [7:0] ADR_COUNT = 8'h14;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADR_STATUS = 8'h1C;

	// clock select register fields
	localparam int LOW_SEL_LSB = 0;
	localparam int HIGH_SEL_LSB = 4;
	localparam int SEL_W = 4;

	// timer mode control bits
	localparam int BIT_COUNT_RUN = 0;
	localparam int BIT_COUNT_RUN_B = 1;
	localparam int BIT_CASCADE = 2;

	// output control bits
	localparam int BIT_OUT_A_EN = 0;
	localparam int BIT_OUT_A_SET = 2;
	localparam int BIT_OUT_A_RST = 3;
	localparam int BIT_OUT_B_EN = 4;

	// mask and status bits
	localparam int BIT_LOW_MASK = 0;
	localparam int BIT_STAT_OUT_A = 0;
	localparam int BIT_STAT_OUT_B = 1;

	// count source select codes
	localparam logic [3:0] SEL_EVT_FALL = 4'h0;
	localparam logic [3:0] SEL_EVT_RISE = 4'h1;
	localparam logic [3:0] SEL_DIV_FIRST = 4'h6;
	localparam logic [3:0] SEL_DIV_LAST = 4'hE;
	localparam logic [3:0] SEL_DIV_TOP = 4'hF;
	localparam logic [3:0] SEL_DIV_BIAS = 4'h4;
	localparam int DIV_TOP_LOG2 = 12;

	// widths and reset values
	localparam int CNT_W = 8;
	localparam int PRE_W = 12;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
endpackage
`default_nettype wire

//--- verilog/dtsw_prescaler.sv
`default_nettype none
module dtsw_prescaler
	import dtsw_pkg::*;
#(
	parameter int WIDTH = PRE_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	output logic [WIDTH-1:0] count
);
	// the divide taps need at least the top divisor's width
	if (WIDTH < DIV_TOP_LOG2) begin
		$error("prescaler too narrow");
	end

	// free-running divider; taps are decoded by the user
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else begin
			count <= count + WIDTH'(1);
		end
	end
endmodule
`default_nettype wire

//--- verilog/dtsw_edge_sync.sv
`default_nettype none
module dtsw_edge_sync (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// three stages; only the second and third are compared
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// accepted level moves only once stages two and three agree, so a one-cycle glitch never counts
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	// one-cycle edge pulses against the accepted level
	assign rise = s2_r & s3_r & ~level_r;
	assign fall = ~s2_r & ~s3_r & level_r;
endmodule
`default_nettype wire

//--- verilog/dtsw_top.sv
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`default_nettype none
module dtsw_top
	import dtsw_pkg::*;
#(
	parameter int PRESCALE_W = PRE_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic event_in_a,
	input wire logic event_in_b,
	output logic square_out_a,
	output logic square_out_b,
	output logic low_match_irq,
	output logic high_match_irq
);
	// refuse a divider too short to reach the top tap
	if (PRESCALE_W < DIV_TOP_LOG2) begin
		$error("prescale width cannot reach the top divisor");
	end

	// software visible state
	logic [7:0] clock_select_reg_r;
	logic [7:0] timer_mode_ctrl_r;
	logic out_a_enable_r;
	logic out_b_enable_r;
	logic [7:0] low_compare_r;
	logic [7:0] high_compare_r;
	logic low_match_irq_mask_r;

	// counting state
	logic [7:0] low_counter_r;
	logic [7:0] high_counter_r;
	logic [7:0] low_counter_nxt;
	logic [7:0] high_counter_nxt;

	// bus and event wiring
	logic [PRESCALE_W-1:0] pre_cnt;
	logic rise_a;
	logic fall_a;
	logic rise_b;
	logic fall_b;
	logic req;
	logic wr_en;
	logic byte0_wr;
	logic out_ctrl_wr;
	logic force_set;
	logic force_rst;
	logic [31:0] rd_nxt;

	// mode decode
	logic cascade_select;
	logic count_run;
	logic count_run_b;
	logic [3:0] low_clock_select;
	logic [3:0] high_clock_select;
	logic tick_a;
	logic tick_b;
	logic low_eq;
	logic high_eq;
	logic match_a;
	logic match_b;
	logic full_match;
	logic low_wrap;

	// tap test: low k bits of the divider all ones gives one pulse per 2^k clocks
	function automatic logic tap_hit(input logic [PRESCALE_W-1:0] pre, input int k);
		logic [PRESCALE_W-1:0] mask;
		mask = PRESCALE_W'((64'h1 << k) - 64'h1);
		return (pre & mask) == mask;
	endfunction

	// count pulse chosen by one select field
	function automatic logic src_tick(
		input logic [3:0] code,
		input logic [PRESCALE_W-1:0] pre,
		input logic rise,
		input logic fall
	);
		logic hit;
		hit = 1'b0;
		if (code == SEL_EVT_FALL) begin
			hit = fall;
		end else if (code == SEL_EVT_RISE) begin
			hit = rise;
		end else if (code >= SEL_DIV_FIRST && code <= SEL_DIV_LAST) begin
			hit = tap_hit(pre, int'(code - SEL_DIV_BIAS));
		end else if (code == SEL_DIV_TOP) begin
			hit = tap_hit(pre, DIV_TOP_LOG2);
		end
		// forbidden codes never count, so a bad setting just stalls the channel
		return hit;
	endfunction

	// counters wrap from all ones, which the cascade relies on
	function automatic logic [7:0] step_up(input logic [7:0] v);
		return v + 8'h01;
	endfunction

	// 8-bit mode step: own match clears, anything else counts up
	function automatic logic [7:0] clear_or_step(input logic [7:0] v, input logic eq);
		return eq ? RST_BYTE : step_up(v);
	endfunction

	dtsw_prescaler #(
		.WIDTH(PRESCALE_W)
	) u_pre (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.count(pre_cnt)
	);

	dtsw_edge_sync u_sync_a (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin(event_in_a),
		.rise(rise_a),
		.fall(fall_a)
	);

	dtsw_edge_sync u_sync_b (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin(event_in_b),
		.rise(rise_b),
		.fall(fall_b)
	);

	// bus request decode; ack_o low keeps a new request to one cycle
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_en = req & wb_we_i;
	assign byte0_wr = wr_en & wb_sel_i[0];
	assign out_ctrl_wr = byte0_wr && wb_adr_i == ADR_OUT_CTRL;
	assign force_set = out_ctrl_wr && wb_dat_i[BIT_OUT_A_SET];
	assign force_rst = out_ctrl_wr && wb_dat_i[BIT_OUT_A_RST];

	// field decode
	assign cascade_select = timer_mode_ctrl_r[BIT_CASCADE];
	assign count_run = timer_mode_ctrl_r[BIT_COUNT_RUN];
	assign count_run_b = timer_mode_ctrl_r[BIT_COUNT_RUN_B];
	assign low_clock_select = clock_select_reg_r[LOW_SEL_LSB +: SEL_W];
	assign high_clock_select = clock_select_reg_r[HIGH_SEL_LSB +: SEL_W];

	// count pulses; the high channel's own source only matters in 8-bit mode
	assign tick_a = count_run & src_tick(low_clock_select, pre_cnt, rise_a, fall_a);
	assign tick_b = count_run_b & src_tick(high_clock_select, pre_cnt, rise_b, fall_b);

	// compare decode
	assign low_eq = low_counter_r == low_compare_r;
	assign high_eq = high_counter_r == high_compare_r;
	assign low_wrap = low_counter_r == CNT_MAX;
	assign match_a = tick_a & low_eq;
	assign full_match = cascade_select & tick_a & low_eq & high_eq;
	assign match_b = cascade_select ? full_match : (tick_b & high_eq);

	// next counts for both modes
	always_comb begin
		low_counter_nxt = low_counter_r;
		high_counter_nxt = high_counter_r;
		if (cascade_select) begin
			if (tick_a) begin
				if (low_eq && high_eq) begin
					// whole 16-bit match restarts the pair at zero
					low_counter_nxt = RST_BYTE;
					high_counter_nxt = RST_BYTE;
				end else begin
					// low byte match alone does not clear in this mode
					low_counter_nxt = step_up(low_counter_r);
					if (low_wrap) begin
						high_counter_nxt = step_up(high_counter_r);
					end
				end
			end
		end else begin
			if (tick_a) begin
				low_counter_nxt = clear_or_step(low_counter_r, low_eq);
			end
			if (tick_b) begin
				high_counter_nxt = clear_or_step(high_counter_r, high_eq);
			end
		end
	end

	// counters
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			low_counter_r <= RST_BYTE;
			high_counter_r <= RST_BYTE;
		end else begin
			low_counter_r <= low_counter_nxt;
			high_counter_r <= high_counter_nxt;
		end
	end

	// control registers written from the bus, byte lane 0 only
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			clock_select_reg_r <= RST_BYTE;
			timer_mode_ctrl_r <= RST_BYTE;
			out_a_enable_r <= 1'b0;
			out_b_enable_r <= 1'b0;
			low_compare_r <= RST_BYTE;
			high_compare_r <= RST_BYTE;
			low_match_irq_mask_r <= 1'b0;
		end else if (byte0_wr) begin
			case (wb_adr_i)
				ADR_CLK_SEL: begin
					clock_select_reg_r <= wb_dat_i[7:0];
				end
				ADR_MODE: begin
					timer_mode_ctrl_r <= wb_dat_i[7:0];
				end
				ADR_OUT_CTRL: begin
					out_a_enable_r <= wb_dat_i[BIT_OUT_A_EN];
					out_b_enable_r <= wb_dat_i[BIT_OUT_B_EN];
				end
				ADR_LOW_CMP: begin
					low_compare_r <= wb_dat_i[7:0];
				end
				ADR_HIGH_CMP: begin
					high_compare_r <= wb_dat_i[7:0];
				end
				ADR_IRQ_MASK: begin
					low_match_irq_mask_r <= wb_dat_i[BIT_LOW_MASK];
				end
				default: begin
					// read-only or unmapped: write is dropped
				end
			endcase
		end
	end

	// output A: software force beats a same-cycle toggle; both forces cancel
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			square_out_a <= 1'b0;
		end else if (force_set && !force_rst) begin
			square_out_a <= 1'b1;
		end else if (force_rst && !force_set) begin
			square_out_a <= 1'b0;
		end else if (match_a && out_a_enable_r) begin
			// match only exists on a running tick, so a stopped pin holds
			square_out_a <= ~square_out_a;
		end
	end

	// output B toggles on its own or on the full 16-bit match
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			square_out_b <= 1'b0;
		end else if (match_b && out_b_enable_r) begin
			square_out_b <= ~square_out_b;
		end
	end

	// request pulses; masking the low one suits the 16-bit interval use
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			low_match_irq <= 1'b0;
			high_match_irq <= 1'b0;
		end else begin
			low_match_irq <= match_a & ~low_match_irq_mask_r;
			high_match_irq <= match_b;
		end
	end

	// read mux; the whole 16-bit count comes in one word so halves never tear
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (wb_adr_i)
			ADR_CLK_SEL: begin
				rd_nxt[7:0] = clock_select_reg_r;
			end
			ADR_MODE: begin
				rd_nxt[7:0] = timer_mode_ctrl_r;
			end
			ADR_OUT_CTRL: begin
				rd_nxt[BIT_OUT_A_EN] = out_a_enable_r;
				rd_nxt[BIT_OUT_B_EN] = out_b_enable_r;
			end
			ADR_LOW_CMP: begin
				rd_nxt[7:0] = low_compare_r;
			end
			ADR_HIGH_CMP: begin
				rd_nxt[7:0] = high_compare_r;
			end
			ADR_COUNT: begin
				rd_nxt[15:0] = {high_counter_r, low_counter_r};
			end
			ADR_IRQ_MASK: begin
				rd_nxt[BIT_LOW_MASK] = low_match_irq_mask_r;
			end
			ADR_STATUS: begin
				rd_nxt[BIT_STAT_OUT_A] = square_out_a;
				rd_nxt[BIT_STAT_OUT_B] = square_out_b;
			end
			default: begin
				rd_nxt = 32'h0000_0000;
			end
		endcase
	end

	// single-wait-state answer: ack one cycle after the request is seen
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= rd_nxt;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/dtsw_top_asserts.sv
`default_nettype none
module dtsw_checker
	import dtsw_pkg::*;
#(
	parameter int PRESCALE_W = PRE_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic square_out_a,
	input wire logic square_out_b,
	input wire logic low_match_irq,
	input wire logic high_match_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// one clock domain, so one default clock and reset
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// bus answer: one cycle late, one cycle long, never unasked
	ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without a request");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > ADR_STATUS
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	// requests are single pulses, since ticks never come on back-to-back cycles
	low_pulse_a: assert property (low_match_irq |=> !low_match_irq)
		else $error("low request longer than a pulse");
	high_pulse_a: assert property (high_match_irq |=> !high_match_irq)
		else $error("high request longer than a pulse");
	// pin b moves only together with its match request
	b_toggle_cause_a: assert property ($changed(square_out_b) |-> high_match_irq)
		else $error("pin b moved without a match");
	status_mirror_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADR_STATUS
		|-> wb_dat_o[1:0] == $past({square_out_b, square_out_a}))
		else $error("status read differs from pins");
	cover property (high_match_irq);
	cover property (low_match_irq);
	cover property ($changed(square_out_a));
endmodule
bind dtsw_top dtsw_checker #(.PRESCALE_W(PRESCALE_W)) u_chk (.clk_sys, .reset_n, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .square_out_a, .square_out_b,
	.low_match_irq, .high_match_irq);
`default_nettype wire

//--- tb/dtsw_event_src.sv
`default_nettype none
module dtsw_event_src (
	input wire logic clk_sys,
	output logic event_in_a,
	output logic event_in_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins idle low; each pulse goes to one pin only
	initial begin
		event_in_a = 1'b0;
		event_in_b = 1'b0;
	end
	// three clocks high and four low between pulses, safely above the synchroniser minimum
	task automatic pulse(input logic pin_b, input int k);
		repeat (k) begin
			@(posedge clk_sys);
			{event_in_b, event_in_a} <= pin_b ? 2'b10 : 2'b01;
			repeat (3) @(posedge clk_sys);
			{event_in_b, event_in_a} <= 2'b00;
			repeat (3) @(posedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

//--- tb/dtsw_tb_top.sv
`default_nettype none
module dtsw_tb_top
	import dtsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, s0, s1;
	logic wb_ack_o, event_in_a, event_in_b, square_out_a, square_out_b;
	logic low_match_irq, high_match_irq;
	int fail_count = 0;
	int total_checks = 0;
	int n;
	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;
	dtsw_top uut (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .event_in_a, .event_in_b, .square_out_a,
		.square_out_b, .low_match_irq, .high_match_irq);
	dtsw_event_src src (.clk_sys, .event_in_a, .event_in_b);
	task automatic results;
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// classic single cycle; read data lands in s1
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		s1 = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (wb_ack_o !== 1'b1) begin
			fail_count++;
			results();
		end
	endtask
	task automatic rst;
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
	endtask
	// n ends as the cycle count since this call began
	task automatic wait_irq(input logic hi);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while ((hi ? high_match_irq : low_match_irq) !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			fail_count++;
			results();
		end
	endtask
	// two waits first, so a partial interval after setup is discarded
	task automatic period(input logic hi, input int exp);
		repeat (2) wait_irq(hi);
		chk("interval", n, exp);
		wb(1'b0, ADR_STATUS, 32'h0);
		s0 = s1;
		wait_irq(hi);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("output toggle", {31'h0, s1[hi] ^ s0[hi]}, 32'h1);
	endtask
	// main sequence
	initial begin
		rst();
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("status", s1, 32'h0);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", s1, 32'h0);
		wb(1'b1, ADR_LOW_CMP, 32'h2);
		wb(1'b1, ADR_OUT_CTRL, 32'h11);
		wb(1'b1, ADR_CLK_SEL, 32'h6);
		wb(1'b1, ADR_MODE, 32'h1);
		period(1'b0, 12);
		wb(1'b1, ADR_LOW_CMP, 32'h0);
		for (int c = 6; c < 16; c++) begin
			wb(1'b1, ADR_CLK_SEL, c);
			repeat (3) wait_irq(1'b0);
			chk("tap interval", n, c == 15 ? 4096 : 1 << (c - 4));
		end
		wb(1'b1, ADR_HIGH_CMP, 32'h3);
		wb(1'b1, ADR_CLK_SEL, 32'h60);
		wb(1'b1, ADR_MODE, 32'h2);
		period(1'b1, 16);
		wb(1'b1, ADR_MODE, 32'h0);
		wb(1'b0, ADR_STATUS, 32'h0);
		s0 = s1;
		repeat (100) @(posedge clk_sys);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("held outputs", s1, s0);
		// reset, set, reset: each force has to move the pin at least once
		for (int f = 0; f < 3; f++) begin
			wb(1'b1, ADR_OUT_CTRL, f == 1 ? 32'h15 : 32'h19);
			wb(1'b0, ADR_STATUS, 32'h0);
			chk("forced level", s1[0], f == 1);
		end
		// cascade from a clean start, so the pair never wraps the full span
		rst();
		wb(1'b1, ADR_OUT_CTRL, 32'h11);
		wb(1'b1, ADR_CLK_SEL, 32'h6);
		wb(1'b1, ADR_HIGH_CMP, 32'h1);
		wb(1'b1, ADR_LOW_CMP, 32'h1);
		wb(1'b1, ADR_MODE, 32'h5);
		period(1'b1, 1032);
		wait_irq(1'b0);
		wb(1'b1, ADR_IRQ_MASK, 32'h1);
		n = 0;
		repeat (1200) begin
			@(posedge clk_sys);
			if (low_match_irq === 1'b1) n++;
		end
		chk("masked requests", n, 0);
		wb(1'b1, ADR_MODE, 32'h4);
		wb(1'b0, ADR_COUNT, 32'h0);
		s0 = s1;
		repeat (50) @(posedge clk_sys);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("stopped count", s1, s0);
		rst();
		wb(1'b1, ADR_CLK_SEL, 32'h1);
		wb(1'b1, ADR_HIGH_CMP, 32'h1);
		wb(1'b1, ADR_LOW_CMP, 32'h4);
		wb(1'b1, ADR_MODE, 32'h5);
		src.pulse(1'b0, 258);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("event count", s1[15:0], 16'h0102);
		src.pulse(1'b0, 3);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("count after match", s1[15:0], 16'h0000);
		wb(1'b1, ADR_CLK_SEL, 32'h0);
		src.pulse(1'b0, 2);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("falling edge count", s1[15:0], 16'h0002);
		// 8-bit mode: pin b alone steps the high channel through its own field
		rst();
		wb(1'b1, ADR_CLK_SEL, 32'h10);
		wb(1'b1, ADR_HIGH_CMP, 32'hFF);
		wb(1'b1, ADR_MODE, 32'h2);
		src.pulse(1'b1, 5);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("event count b", s1[15:0], 16'h0500);
		results();
	end
endmodule
`default_nettype wire
